//--- verilog/ccs_pkg.sv
`default_nettype none
package ccs_pkg;
  localparam logic [15:0] CSR_ADDR = 16'hEF00;
  localparam logic [15:0] CSR_RESET = 16'h0001;

  localparam int INIT_BIT = 0;
  localparam int GIE_BIT = 1;
  localparam int SIE_BIT = 2;
  localparam int EIE_BIT = 3;
  localparam int BYP_BIT = 4;
  localparam int CCE_BIT = 6;
  localparam int TST_BIT = 7;
  localparam int LEC_LSB = 8;
  localparam int LEC_MSB = 10;
  localparam int TRANSMIT_SUCCESS_FLAG_BIT = 11;
  localparam int RECEIVE_SUCCESS_FLAG_BIT = 12;
  localparam int WRN_BIT = 14;
  localparam int BUSOFF_FLAG_BIT = 15;

  localparam logic [2:0] LEC_NONE = 3'h0;
  localparam logic [2:0] LEC_STUFF = 3'h1;
  localparam logic [2:0] LEC_FORM = 3'h2;
  localparam logic [2:0] LEC_ACK = 3'h3;
  localparam logic [2:0] LEC_BIT1 = 3'h4;
  localparam logic [2:0] LEC_BIT0 = 3'h5;
  localparam logic [2:0] LEC_CRC = 3'h6;
  localparam logic [2:0] LEC_UNUSED = 3'h7;

  // standard mode halves the module clock
  localparam logic [0:0] PRESCALE_STD_LAST = 1'h1;

  typedef enum logic [1:0] {
    CCS_PRE_LOW = 2'b01,
    CCS_PRE_HIGH = 2'b10
  } ccs_pre_e;
endpackage : ccs_pkg
`default_nettype wire

//--- verilog/ccs_prescaler_if.sv
`default_nettype none
interface ccs_prescaler_if;
  logic bypass;
  logic hold;
  logic tick;
  modport ctl (output bypass, output hold, input tick);
  modport pre (input bypass, input hold, output tick);
endinterface : ccs_prescaler_if
`default_nettype wire

//--- verilog/ccs_prescaler.sv
`default_nettype none
module ccs_prescaler (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // control and tick
  ccs_prescaler_if.pre pif
);
  ccs_pkg::ccs_pre_e state_q;
  logic tick_q;

  // phase of the 2:1 divider; held still during initialization
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_q <= ccs_pkg::CCS_PRE_LOW;
    end
    else if (pif.hold || pif.bypass)
    begin
      state_q <= ccs_pkg::CCS_PRE_LOW;
    end
    else
    begin
      case (state_q)
        ccs_pkg::CCS_PRE_LOW: state_q <= ccs_pkg::CCS_PRE_HIGH;
        ccs_pkg::CCS_PRE_HIGH: state_q <= ccs_pkg::CCS_PRE_LOW;
        default: state_q <= ccs_pkg::CCS_PRE_LOW;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      tick_q <= 1'b0;
    end
    else if (pif.hold)
    begin
      tick_q <= 1'b0;
    end
    else if (pif.bypass)
    begin
      tick_q <= 1'b1;
    end
    else
    begin
      tick_q <= (state_q == ccs_pkg::CCS_PRE_HIGH);
    end
  end

  assign pif.tick = tick_q;
endmodule : ccs_prescaler
`default_nettype wire

//--- verilog/ccs_top.sv
`default_nettype none
module ccs_top (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // register port
  input wire logic BUS_SEL,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic [15:0] BUS_ADDR,
  input wire logic [1:0] BUS_BE,
  input wire logic [15:0] BUS_WDATA,
  output logic [15:0] BUS_RDATA,
  // events from the bit stream processor
  input wire logic EVT_TX_OK,
  input wire logic EVT_RX_OK,
  input wire logic EVT_ERR,
  input wire logic [2:0] EVT_ERR_CODE,
  input wire logic EVT_RECOVERY_STEP,
  // levels from the error management logic
  input wire logic BUSOFF_STATE,
  input wire logic WARNING_STATE,
  // configuration write gating
  input wire logic CFG_WR_REQ,
  output logic CFG_WR_STROBE,
  // pending-interrupt acknowledge from the identifier logic
  input wire logic ERR_IRQ_ACK,
  // control outputs
  output logic INIT_HOLD,
  output logic BIT_TIMING_TICK,
  output logic TEST_MODE,
  output logic STATUS_IRQ_PENDING,
  output logic ERROR_IRQ_PENDING,
  output logic MODULE_IRQ_OUTPUT
);
  logic init_q;
  logic gie_q;
  logic sie_q;
  logic eie_q;
  logic byp_q;
  logic cce_q;
  logic tst_q;
  logic [2:0] lec_q;
  logic [2:0] lec_d;
  logic transmit_success_flag_q;
  logic receive_success_flag_q;
  logic busoff_flag_q;
  logic wrn_q;
  logic stat_pend_q;
  logic err_pend_q;
  logic [15:0] rdata_q;
  logic [15:0] csr_view;
  logic hit;
  logic wr_lo;
  logic wr_hi;
  logic rd_hi;
  logic rd_any;
  logic busoff_flag_rise;
  logic lvl_change;
  logic stat_event;
  logic err_code_valid;

  ccs_prescaler_if pif ();

  ccs_prescaler u_prescaler (
    .CORE_CLK(CORE_CLK),
    .RSTN(RSTN),
    .pif(pif)
  );

  assign hit = BUS_SEL && (BUS_ADDR == ccs_pkg::CSR_ADDR);
  assign wr_lo = hit && BUS_WR && BUS_BE[0];
  assign wr_hi = hit && BUS_WR && BUS_BE[1];
  assign rd_any = hit && BUS_RD;
  assign rd_hi = rd_any && BUS_BE[1];

  // busoff is sampled into the status half
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      busoff_flag_q <= 1'b0;
    end
    else
    begin
      busoff_flag_q <= BUSOFF_STATE;
    end
  end

  // warning level, also the reference for its change detector
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      wrn_q <= 1'b0;
    end
    else
    begin
      wrn_q <= WARNING_STATE;
    end
  end

  assign busoff_flag_rise = BUSOFF_STATE && !busoff_flag_q;
  assign lvl_change = (BUSOFF_STATE != busoff_flag_q) || (WARNING_STATE != wrn_q);

  // hardware never reports the unused code
  assign err_code_valid = EVT_ERR && (EVT_ERR_CODE != ccs_pkg::LEC_UNUSED);

  // init bit: reset value, busoff entry and software writes
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      init_q <= ccs_pkg::CSR_RESET[ccs_pkg::INIT_BIT];
    end
    else if (busoff_flag_rise)
    begin
      init_q <= 1'b1;
    end
    else if (wr_lo)
    begin
      init_q <= BUS_WDATA[ccs_pkg::INIT_BIT];
    end
  end

  // interrupt enables of the low byte
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      gie_q <= ccs_pkg::CSR_RESET[ccs_pkg::GIE_BIT];
      sie_q <= ccs_pkg::CSR_RESET[ccs_pkg::SIE_BIT];
      eie_q <= ccs_pkg::CSR_RESET[ccs_pkg::EIE_BIT];
    end
    else if (wr_lo)
    begin
      gie_q <= BUS_WDATA[ccs_pkg::GIE_BIT];
      sie_q <= BUS_WDATA[ccs_pkg::SIE_BIT];
      eie_q <= BUS_WDATA[ccs_pkg::EIE_BIT];
    end
  end

  // prescaler mode and configuration gate
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      byp_q <= ccs_pkg::CSR_RESET[ccs_pkg::BYP_BIT];
      cce_q <= ccs_pkg::CSR_RESET[ccs_pkg::CCE_BIT];
    end
    else if (wr_lo)
    begin
      byp_q <= BUS_WDATA[ccs_pkg::BYP_BIT];
      cce_q <= BUS_WDATA[ccs_pkg::CCE_BIT];
    end
  end

  // test bit
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      tst_q <= ccs_pkg::CSR_RESET[ccs_pkg::TST_BIT];
    end
    else if (wr_lo)
    begin
      // stored as written; software keeps it zero
      tst_q <= BUS_WDATA[ccs_pkg::TST_BIT];
    end
  end

  // error code: hardware result beats a software write in the same cycle
  always_comb
  begin
    lec_d = lec_q;
    if (wr_hi)
    begin
      lec_d = BUS_WDATA[ccs_pkg::LEC_MSB:ccs_pkg::LEC_LSB];
    end
    if (EVT_TX_OK || EVT_RX_OK)
    begin
      lec_d = ccs_pkg::LEC_NONE;
    end
    if (EVT_RECOVERY_STEP)
    begin
      lec_d = ccs_pkg::LEC_BIT0;
    end
    if (err_code_valid)
    begin
      // stuff, form, ack, bit1, bit0 and crc codes pass straight in
      lec_d = EVT_ERR_CODE;
    end
  end

  // updates continue whatever the interrupt enables say
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      lec_q <= ccs_pkg::LEC_NONE;
    end
    else
    begin
      lec_q <= lec_d;
    end
  end

  // success flags: set wins over a clearing write
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      transmit_success_flag_q <= 1'b0;
      receive_success_flag_q <= 1'b0;
    end
    else
    begin
      if (EVT_TX_OK)
      begin
        transmit_success_flag_q <= 1'b1;
      end
      else if (wr_hi)
      begin
        transmit_success_flag_q <= BUS_WDATA[ccs_pkg::TRANSMIT_SUCCESS_FLAG_BIT];
      end
      if (EVT_RX_OK)
      begin
        receive_success_flag_q <= 1'b1;
      end
      else if (wr_hi)
      begin
        receive_success_flag_q <= BUS_WDATA[ccs_pkg::RECEIVE_SUCCESS_FLAG_BIT];
      end
    end
  end

  assign stat_event = EVT_TX_OK || EVT_RX_OK || err_code_valid;

  // status-change pending: an event in the clearing read cycle survives
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      stat_pend_q <= 1'b0;
    end
    else if (sie_q && stat_event)
    begin
      stat_pend_q <= 1'b1;
    end
    else if (rd_hi)
    begin
      stat_pend_q <= 1'b0;
    end
  end

  // error pending is released by the identifier logic once serviced
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      err_pend_q <= 1'b0;
    end
    else if (eie_q && lvl_change)
    begin
      err_pend_q <= 1'b1;
    end
    else if (ERR_IRQ_ACK)
    begin
      err_pend_q <= 1'b0;
    end
  end

  always_comb
  begin
    csr_view = 16'h0000;
    csr_view[ccs_pkg::INIT_BIT] = init_q;
    csr_view[ccs_pkg::GIE_BIT] = gie_q;
    csr_view[ccs_pkg::SIE_BIT] = sie_q;
    csr_view[ccs_pkg::EIE_BIT] = eie_q;
    csr_view[ccs_pkg::BYP_BIT] = byp_q;
    csr_view[ccs_pkg::CCE_BIT] = cce_q;
    csr_view[ccs_pkg::TST_BIT] = tst_q;
    csr_view[ccs_pkg::LEC_MSB:ccs_pkg::LEC_LSB] = lec_q;
    csr_view[ccs_pkg::TRANSMIT_SUCCESS_FLAG_BIT] = transmit_success_flag_q;
    csr_view[ccs_pkg::RECEIVE_SUCCESS_FLAG_BIT] = receive_success_flag_q;
    csr_view[ccs_pkg::WRN_BIT] = wrn_q;
    csr_view[ccs_pkg::BUSOFF_FLAG_BIT] = busoff_flag_q;
  end

  // read data registered; unmapped reads return zero
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rdata_q <= 16'h0000;
    end
    else if (BUS_SEL && BUS_RD)
    begin
      rdata_q <= rd_any ? csr_view : 16'h0000;
    end
  end

  assign pif.bypass = byp_q;
  assign pif.hold = init_q;

  assign BUS_RDATA = rdata_q;
  assign INIT_HOLD = init_q;
  assign BIT_TIMING_TICK = pif.tick;
  assign TEST_MODE = tst_q;
  assign CFG_WR_STROBE = CFG_WR_REQ && cce_q;
  assign STATUS_IRQ_PENDING = stat_pend_q;
  assign ERROR_IRQ_PENDING = err_pend_q;
  assign MODULE_IRQ_OUTPUT = gie_q && (stat_pend_q || err_pend_q);
endmodule : ccs_top
`default_nettype wire

//--- bench/ccs_top_properties.sv
`default_nettype none
module ccs_checker (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // register port
  input wire logic BUS_SEL,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic [15:0] BUS_ADDR,
  input wire logic [1:0] BUS_BE,
  input wire logic [15:0] BUS_WDATA,
  input wire logic [15:0] BUS_RDATA,
  // events and levels
  input wire logic EVT_TX_OK,
  input wire logic EVT_RX_OK,
  input wire logic EVT_ERR,
  input wire logic BUSOFF_STATE,
  input wire logic WARNING_STATE,
  input wire logic CFG_WR_REQ,
  input wire logic CFG_WR_STROBE,
  // outputs
  input wire logic INIT_HOLD,
  input wire logic BIT_TIMING_TICK,
  input wire logic STATUS_IRQ_PENDING,
  input wire logic ERROR_IRQ_PENDING,
  input wire logic MODULE_IRQ_OUTPUT
);
  logic [7:0] ctl_q;
  logic hit;
  logic wr_lo;
  assign hit = BUS_SEL && (BUS_ADDR == ccs_pkg::CSR_ADDR);
  assign wr_lo = hit && BUS_WR && BUS_BE[0];
  // shadow of the control byte; its init bit goes unchecked since busoff also sets it
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
      ctl_q <= 8'h00;
    else if (wr_lo)
      ctl_q <= BUS_WDATA[7:0];
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  a_init_stops_tick: assert property (INIT_HOLD [*2] |-> !BIT_TIMING_TICK)
    else $error("tick while init held");
  a_busoff_sets_init: assert property ($rose(BUSOFF_STATE) |=> INIT_HOLD)
    else $error("busoff entry did not set init");
  a_irq_needs_pending: assert property (MODULE_IRQ_OUTPUT |-> STATUS_IRQ_PENDING || ERROR_IRQ_PENDING)
    else $error("interrupt without pending cause");
  a_irq_when_enabled: assert property (ctl_q[1] && STATUS_IRQ_PENDING |-> MODULE_IRQ_OUTPUT)
    else $error("enabled pending interrupt not driven");
  a_status_pend_rx: assert property (ctl_q[2] && EVT_RX_OK |=> STATUS_IRQ_PENDING)
    else $error("status interrupt missing");
  a_error_pend_change: assert property (ctl_q[3] && $changed(BUSOFF_STATE) |=> ERROR_IRQ_PENDING)
    else $error("error interrupt missing");
  a_warn_pend_change: assert property (ctl_q[3] && $changed(WARNING_STATE) |=> ERROR_IRQ_PENDING)
    else $error("warning change interrupt missing");
  a_tick_half_rate: assert property (!ctl_q[4] && !wr_lo && BIT_TIMING_TICK |=> !BIT_TIMING_TICK)
    else $error("tick too fast in standard mode");
  a_tick_full_rate: assert property (ctl_q[4] && !INIT_HOLD |=> BIT_TIMING_TICK)
    else $error("tick missing in fast mode");
  a_cfg_write_gate: assert property (CFG_WR_STROBE == (CFG_WR_REQ && ctl_q[6]))
    else $error("config write gate wrong");
  a_reserved_bits_zero: assert property (BUS_SEL && BUS_RD |=> !BUS_RDATA[5] && !BUS_RDATA[13])
    else $error("reserved bit read as one");
  a_read_clears_status: assert property (hit && BUS_RD && BUS_BE[1] && !EVT_TX_OK && !EVT_RX_OK && !EVT_ERR
    |=> !STATUS_IRQ_PENDING)
    else $error("upper read left status pending");
endmodule : ccs_checker
bind ccs_top ccs_checker ccs_checker_inst (.CORE_CLK, .RSTN, .BUS_SEL, .BUS_WR, .BUS_RD, .BUS_ADDR, .BUS_BE,
  .BUS_WDATA, .BUS_RDATA, .EVT_TX_OK, .EVT_RX_OK, .EVT_ERR, .BUSOFF_STATE, .CFG_WR_REQ, .CFG_WR_STROBE,
  .INIT_HOLD, .BIT_TIMING_TICK, .STATUS_IRQ_PENDING, .ERROR_IRQ_PENDING, .MODULE_IRQ_OUTPUT, .WARNING_STATE);
`default_nettype wire

//--- bench/ccs_can_partner.sv
`default_nettype none
module ccs_can_partner (
  // clock
  input wire logic clk,
  // frame outcomes
  output logic [3:0] ev,
  output logic [2:0] err_code,
  // error management levels
  output logic busoff_flag,
  output logic wrn
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    ev = 4'h0;
    err_code = 3'h0;
    busoff_flag = 1'b0;
    wrn = 1'b0;
  end
  // ev is {recovery step, error, rx ok, tx ok}, one cycle per outcome
  task automatic frame(input logic [3:0] e, input logic [2:0] c);
    @(posedge clk) #1;
    ev = e;
    err_code = (c == ccs_pkg::LEC_UNUSED) ? ccs_pkg::LEC_NONE : c;
    @(posedge clk) #1;
    ev = 4'h0;
    // code is meaningless outside a pulse, so keep it moving
    err_code = ~err_code;
  endtask : frame
  task automatic level(input logic b, input logic w);
    @(posedge clk) #1;
    busoff_flag = b;
    wrn = w;
  endtask : level
endmodule : ccs_can_partner
`default_nettype wire

//--- bench/ccs_top_test.sv
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module ccs_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] A = ccs_pkg::CSR_ADDR;
  logic clk = 1'b0, rstn = 1'b0, sel = 1'b0, wr = 1'b0, rd = 1'b0, cfg_req = 1'b0, ack = 1'b0;
  logic [1:0] be = 2'h0;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, r;
  logic [3:0] ev;
  logic [2:0] code, c;
  logic busoff_flag, wrn, strobe, init, tick, test, spend, epend, irq;
  int num_errors = 0, comparisons = 0;
  always #25 clk = ~clk;
  ccs_can_partner ccs_can_partner_inst (.clk(clk), .ev(ev), .err_code(code), .busoff_flag(busoff_flag), .wrn(wrn));
  ccs_top ccs_top_inst (.CORE_CLK(clk), .RSTN(rstn), .BUS_SEL(sel), .BUS_WR(wr), .BUS_RD(rd),
    .BUS_ADDR(addr), .BUS_BE(be), .BUS_WDATA(wdata), .BUS_RDATA(rdata), .EVT_TX_OK(ev[0]),
    .EVT_RX_OK(ev[1]), .EVT_ERR(ev[2]), .EVT_ERR_CODE(code), .EVT_RECOVERY_STEP(ev[3]),
    .BUSOFF_STATE(busoff_flag), .WARNING_STATE(wrn), .CFG_WR_REQ(cfg_req), .CFG_WR_STROBE(strobe),
    .ERR_IRQ_ACK(ack), .INIT_HOLD(init), .BIT_TIMING_TICK(tick), .TEST_MODE(test),
    .STATUS_IRQ_PENDING(spend), .ERROR_IRQ_PENDING(epend), .MODULE_IRQ_OUTPUT(irq));
  task automatic acc(input logic w, input logic [1:0] b, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk) #1;
    {sel, wr, rd, be, addr, wdata} = {1'b1, w, !w, b, a, d};
    @(posedge clk) #1;
    {sel, wr, rd} = 3'h0;
    r = rdata;
  endtask : acc
  task automatic ticks(input logic [3:0] e);
    logic [3:0] n;
    n = 4'h0;
    repeat (8)
    begin
      @(posedge clk) #1;
      n = n + {3'h0, tick};
    end
    `CHK(n, e)
  endtask : ticks
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  initial
  begin
    #100000;
    num_errors++;
    complete_run();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    #1 rstn = 1'b1;
    acc(1'b0, 2'h3, A, 16'h0000);
    `CHK(r, ccs_pkg::CSR_RESET)
    `CHK(init, 1'b1)
    `CHK(tick, 1'b0)
    $display("reset test done");
    acc(1'b1, 2'h3, A, 16'hFF5E);
    acc(1'b0, 2'h3, A, 16'h0000);
    `CHK(r, 16'h1F5E)
    `CHK(test, 1'b0)
    ticks(4'h8);
    acc(1'b1, 2'h1, A, 16'h004E);
    ticks(4'h4);
    cfg_req = 1'b1;
    #1;
    `CHK(strobe, 1'b1)
    acc(1'b1, 2'h1, A, 16'h000E);
    `CHK(strobe, 1'b0)
    cfg_req = 1'b0;
    $display("control test done");
    acc(1'b1, 2'h2, A, 16'h0000);
    for (int i = 1; i < 7; i++)
    begin
      c = i[2:0];
      ccs_can_partner_inst.frame(4'h4, c);
      `CHK({spend, irq}, 2'b11)
      acc(1'b0, 2'h2, A, 16'h0000);
      `CHK(r[10:8], c)
      `CHK(spend, 1'b0)
    end
    ccs_can_partner_inst.frame(4'h1, 3'h0);
    acc(1'b0, 2'h1, A, 16'h0000);
    `CHK(spend, 1'b1)
    acc(1'b0, 2'h2, A, 16'h0000);
    `CHK(r[12:8], 5'h08)
    `CHK(r[10:8], ccs_pkg::LEC_NONE)
    ccs_can_partner_inst.frame(4'h8, 3'h0);
    acc(1'b0, 2'h2, A, 16'h0000);
    `CHK(r[10:8], ccs_pkg::LEC_BIT0)
    $display("error code test done");
    ccs_can_partner_inst.level(1'b1, 1'b1);
    @(posedge clk) #1;
    `CHK({init, epend}, 2'b11)
    acc(1'b0, 2'h2, A, 16'h0000);
    `CHK(r[15:14], 2'b11)
    `CHK(irq, 1'b1)
    ack = 1'b1;
    @(posedge clk) #1;
    ack = 1'b0;
    @(posedge clk) #1;
    `CHK(epend, 1'b0)
    acc(1'b1, 2'h1, A, 16'h0004);
    ccs_can_partner_inst.frame(4'h2, 3'h0);
    `CHK({spend, irq}, 2'b10)
    acc(1'b0, 2'h2, A, 16'h0000);
    `CHK(r[12:11], 2'b11)
    ccs_can_partner_inst.level(1'b0, 1'b0);
    @(posedge clk) #1;
    `CHK(epend, 1'b0)
    acc(1'b1, 2'h1, A, 16'h0008);
    ccs_can_partner_inst.level(1'b0, 1'b1);
    @(posedge clk) #1;
    `CHK({epend, irq}, 2'b10)
    acc(1'b0, 2'h3, 16'hEF02, 16'h0000);
    `CHK(r, 16'h0000)
    $display("status test done");
    complete_run();
  end
endmodule : ccs_top_test
`default_nettype wire
